// [design/orx_exec.v]
`timescale 1ns/1ps
`default_nettype none
`include "orx_regs.vh"

module orx_exec (
    input  wire                       SYS_CLK,
    input  wire                       SYS_RST,
    input  wire                       OP_VALID,
    input  wire [`ORX_OP_W-1:0]       OP_CODE,
    input  wire [`ORX_DATA_W-1:0]     OP_IMM,
    input  wire [`ORX_ADDR_W-1:0]     OP_ADDR,
    input  wire [`ORX_DATA_W-1:0]     MEM_RDATA,
    input  wire [`ORX_PC_W-1:0]       STACK_TOP,
    input  wire                       IRQ_PENDING,
    output reg                        OP_BUSY,
    output reg                        OP_DONE,
    output reg  [`ORX_ADDR_W-1:0]     MEM_ADDR,
    output reg                        MEM_RD,
    output reg                        MEM_WR,
    output reg  [`ORX_DATA_W-1:0]     MEM_WDATA,
    output reg                        STACK_POP,
    output reg                        PC_LOAD,
    output reg  [`ORX_PC_W-1:0]       PC_VALUE,
    output reg                        IRQ_TAKE,
    output reg  [`ORX_DATA_W-1:0]     WORK_REG,
    output reg                        NIL_FLAG,
    output reg                        INT_ENABLE
);

    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    function [`ORX_DATA_W-1:0] rot_left;
        input [`ORX_DATA_W-1:0] v;
        begin
            rot_left = {v[`ORX_MSB-1:0], v[`ORX_MSB]};
        end
    endfunction

    function is_nil;
        input [`ORX_DATA_W-1:0] v;
        begin
            is_nil = (v == `ORX_ZERO8);
        end
    endfunction

    function [`ORX_DATA_W-1:0] or_byte;
        input [`ORX_DATA_W-1:0] a;
        input [`ORX_DATA_W-1:0] b;
        begin
            or_byte = a | b;
        end
    endfunction

    // -----------------------------------------------------------
    // sequencer states
    // -----------------------------------------------------------
    localparam [`ORX_ST_W-1:0] ST_IDLE  = `ORX_ST_IDLE;
    localparam [`ORX_ST_W-1:0] ST_READ  = `ORX_ST_READ;
    localparam [`ORX_ST_W-1:0] ST_WRITE = `ORX_ST_WRITE;

    // -----------------------------------------------------------
    // state
    // -----------------------------------------------------------
    reg [`ORX_ST_W-1:0]   state_r;
    reg [`ORX_OP_W-1:0]   op_r;
    reg [`ORX_DATA_W-1:0] imm_res;
    reg [`ORX_DATA_W-1:0] or_res;
    reg [`ORX_DATA_W-1:0] rot_res;

    // -----------------------------------------------------------
    // operand arithmetic
    // -----------------------------------------------------------
    always @*
    begin
        imm_res = or_byte(WORK_REG, OP_IMM);
        or_res  = or_byte(WORK_REG, MEM_RDATA);
        rot_res = rot_left(MEM_RDATA);
    end

    // -----------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------
    always @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            state_r    <= ST_IDLE;
            op_r       <= `ORX_OP_NONE;
            OP_BUSY    <= 1'b0;
            OP_DONE    <= 1'b0;
            MEM_ADDR   <= `ORX_ZERO8;
            MEM_RD     <= 1'b0;
            MEM_WR     <= 1'b0;
            MEM_WDATA  <= `ORX_ZERO8;
            STACK_POP  <= 1'b0;
            PC_LOAD    <= 1'b0;
            PC_VALUE   <= `ORX_ZERO_PC;
            IRQ_TAKE   <= 1'b0;
            WORK_REG   <= `ORX_WORK_RST;
            NIL_FLAG   <= 1'b0;
            INT_ENABLE <= 1'b0;
        end
        else
        begin
            OP_DONE   <= 1'b0;
            MEM_RD    <= 1'b0;
            MEM_WR    <= 1'b0;
            STACK_POP <= 1'b0;
            PC_LOAD   <= 1'b0;
            IRQ_TAKE  <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (OP_VALID)
                    begin
                        op_r <= OP_CODE;
                        case (OP_CODE)
                            `ORX_OP_OR_IMM:
                            begin
                                WORK_REG <= imm_res;
                                NIL_FLAG <= is_nil(imm_res);
                                OP_DONE  <= 1'b1;
                            end

                            `ORX_OP_SUB_EXIT:
                            begin
                                PC_VALUE  <= STACK_TOP;
                                PC_LOAD   <= 1'b1;
                                STACK_POP <= 1'b1;
                                OP_DONE   <= 1'b1;
                            end

                            `ORX_OP_SUB_EXIT_LIT:
                            begin
                                PC_VALUE  <= STACK_TOP;
                                PC_LOAD   <= 1'b1;
                                STACK_POP <= 1'b1;
                                WORK_REG  <= OP_IMM;
                                OP_DONE   <= 1'b1;
                            end

                            `ORX_OP_INT_EXIT:
                            begin
                                PC_VALUE   <= STACK_TOP;
                                PC_LOAD    <= 1'b1;
                                STACK_POP  <= 1'b1;
                                // only set here; cleared only by SYS_RST
                                INT_ENABLE <= 1'b1;
                                // pending handler runs ahead of the restored pc
                                IRQ_TAKE   <= IRQ_PENDING;
                                OP_DONE    <= 1'b1;
                            end

                            `ORX_OP_OR_MEM, `ORX_OP_MEM_ROT, `ORX_OP_ROT_WORK:
                            begin
                                MEM_ADDR <= OP_ADDR;
                                MEM_RD   <= 1'b1;
                                OP_BUSY  <= 1'b1;
                                state_r  <= ST_READ;
                            end

                            default:
                            begin
                                OP_DONE <= 1'b0;
                            end
                        endcase
                    end
                end

                ST_READ:
                begin
                    // memory answers while MEM_RD still stands
                    case (op_r)
                        `ORX_OP_OR_MEM:
                        begin
                            MEM_WDATA <= or_res;
                            MEM_WR    <= 1'b1;
                            NIL_FLAG  <= is_nil(or_res);
                        end

                        `ORX_OP_MEM_ROT:
                        begin
                            MEM_WDATA <= rot_res;
                            MEM_WR    <= 1'b1;
                        end

                        default:
                        begin
                            WORK_REG <= rot_res;
                        end
                    endcase
                    state_r <= ST_WRITE;
                end

                ST_WRITE:
                begin
                    OP_BUSY <= 1'b0;
                    OP_DONE <= 1'b1;
                    state_r <= ST_IDLE;
                end

                default:
                begin
                    state_r <= ST_IDLE;
                    OP_BUSY <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// [include/orx_regs.vh]
`ifndef ORX_REGS_VH
`define ORX_REGS_VH

// ---------------------------------------------------------------
// operation codes presented by the decoder
// ---------------------------------------------------------------
`define ORX_OP_W            3
`define ORX_OP_NONE         3'h0
`define ORX_OP_OR_IMM       3'h1
`define ORX_OP_OR_MEM       3'h2
`define ORX_OP_SUB_EXIT     3'h3
`define ORX_OP_SUB_EXIT_LIT 3'h4
`define ORX_OP_INT_EXIT     3'h5
`define ORX_OP_MEM_ROT      3'h6
`define ORX_OP_ROT_WORK     3'h7

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define ORX_DATA_W          8
`define ORX_ADDR_W          8
`define ORX_PC_W            11
`define ORX_MSB             7
`define ORX_ZERO8           8'h00
`define ORX_ZERO_PC         11'h000
`define ORX_WORK_RST        8'h00

// ---------------------------------------------------------------
// one-hot states
// ---------------------------------------------------------------
`define ORX_ST_W            3
`define ORX_ST_IDLE         3'h1
`define ORX_ST_READ         3'h2
`define ORX_ST_WRITE        3'h4

`endif

// [tb/orx_exec_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module orx_chk (
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    input wire logic        OP_VALID,
    input wire logic        OP_BUSY,
    input wire logic        OP_DONE,
    input wire logic        MEM_WR,
    input wire logic        STACK_POP,
    input wire logic        PC_LOAD,
    input wire logic        IRQ_TAKE,
    input wire logic        IRQ_PENDING,
    input wire logic        NIL_FLAG,
    input wire logic        INT_ENABLE,
    input wire logic [2:0]  OP_CODE,
    input wire logic [7:0]  OP_IMM,
    input wire logic [7:0]  WORK_REG,
    input wire logic [7:0]  MEM_WDATA,
    input wire logic [10:0] STACK_TOP,
    input wire logic [10:0] PC_VALUE
);
    wire logic [2:0] c = OP_VALID && !OP_BUSY ? OP_CODE : 3'h0;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    property p_or;
        c == 3'h1 |=> WORK_REG == ($past(WORK_REG) | $past(OP_IMM)) && NIL_FLAG == !WORK_REG;
    endproperty
    property p_orm;
        c == 3'h2 |-> ##2 (MEM_WR && NIL_FLAG == (MEM_WDATA == 8'h00)
            && (MEM_WDATA | $past(WORK_REG, 2)) == MEM_WDATA) ##1 OP_DONE;
    endproperty
    property p_sub;
        c == 3'h3 |=> STACK_POP && PC_LOAD && PC_VALUE == $past(STACK_TOP)
            && $stable(NIL_FLAG) && $stable(WORK_REG);
    endproperty
    property p_lit; c == 3'h4 |=> WORK_REG == $past(OP_IMM) && $stable(NIL_FLAG); endproperty
    property p_int; c == 3'h5 |=> INT_ENABLE && IRQ_TAKE == $past(IRQ_PENDING); endproperty
    property p_rot; c == 3'h6 |=> $stable(NIL_FLAG)[*2] ##1 OP_DONE; endproperty
    property p_rotw; c == 3'h7 |=> (!MEM_WR && $stable(NIL_FLAG))[*3]; endproperty
    property p_pop; STACK_POP == PC_LOAD; endproperty
    a_or: assert property (p_or) else $error("or imm");
    a_orm: assert property (p_orm) else $error("or mem");
    a_sub: assert property (p_sub) else $error("sub exit");
    a_lit: assert property (p_lit) else $error("lit exit");
    a_int: assert property (p_int) else $error("int exit");
    a_rot: assert property (p_rot) else $error("rot mem");
    a_rotw: assert property (p_rotw) else $error("rot work");
    a_pop: assert property (p_pop) else $error("pop");
    c_int: cover property (c == 3'h5 && IRQ_PENDING);
    c_wr: cover property (MEM_WR);
    c_nil: cover property (c == 3'h1 ##1 NIL_FLAG);
endmodule
bind orx_exec orx_chk u_chk (
    .SYS_CLK     (SYS_CLK),
    .SYS_RST     (SYS_RST),
    .OP_VALID    (OP_VALID),
    .OP_BUSY     (OP_BUSY),
    .OP_DONE     (OP_DONE),
    .MEM_WR      (MEM_WR),
    .STACK_POP   (STACK_POP),
    .PC_LOAD     (PC_LOAD),
    .IRQ_TAKE    (IRQ_TAKE),
    .IRQ_PENDING (IRQ_PENDING),
    .NIL_FLAG    (NIL_FLAG),
    .INT_ENABLE  (INT_ENABLE),
    .OP_CODE     (OP_CODE),
    .OP_IMM      (OP_IMM),
    .WORK_REG    (WORK_REG),
    .MEM_WDATA   (MEM_WDATA),
    .STACK_TOP   (STACK_TOP),
    .PC_VALUE    (PC_VALUE)
);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic             SYS_CLK = 1'b0, SYS_RST = 1'b1, OP_VALID = 1'b0, IRQ_PENDING = 1'b1;
    logic [2:0]       OP_CODE = 3'h0;
    logic [7:0]       OP_IMM = 8'h00, OP_ADDR = 8'h00, mem [0:255];
    logic [10:0]      STACK_TOP = 11'h000;
    wire logic        OP_BUSY, OP_DONE, MEM_RD, MEM_WR, STACK_POP, PC_LOAD, IRQ_TAKE;
    wire logic        NIL_FLAG, INT_ENABLE;
    wire logic [7:0]  MEM_ADDR, MEM_WDATA, WORK_REG;
    wire logic [10:0] PC_VALUE;
    // read port answers at once; shows the inverse when not read
    wire logic [7:0]  MEM_RDATA = (MEM_RD === 1'b1) ? mem[MEM_ADDR] : ~mem[MEM_ADDR];
    int               err_total = 0, total_checks = 0, pops = 0, cyc = 0;
    orx_exec uut (
        .SYS_CLK     (SYS_CLK),
        .SYS_RST     (SYS_RST),
        .OP_VALID    (OP_VALID),
        .OP_CODE     (OP_CODE),
        .OP_IMM      (OP_IMM),
        .OP_ADDR     (OP_ADDR),
        .MEM_RDATA   (MEM_RDATA),
        .STACK_TOP   (STACK_TOP),
        .IRQ_PENDING (IRQ_PENDING),
        .OP_BUSY     (OP_BUSY),
        .OP_DONE     (OP_DONE),
        .MEM_ADDR    (MEM_ADDR),
        .MEM_RD      (MEM_RD),
        .MEM_WR      (MEM_WR),
        .MEM_WDATA   (MEM_WDATA),
        .STACK_POP   (STACK_POP),
        .PC_LOAD     (PC_LOAD),
        .PC_VALUE    (PC_VALUE),
        .IRQ_TAKE    (IRQ_TAKE),
        .WORK_REG    (WORK_REG),
        .NIL_FLAG    (NIL_FLAG),
        .INT_ENABLE  (INT_ENABLE)
    );
    initial forever #10 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK)
    begin
        cyc <= cyc + 1;
        pops <= pops + (STACK_POP === 1'b1);
        if (MEM_WR === 1'b1) mem[MEM_ADDR] <= MEM_WDATA;
        if (cyc == 3000) finish_test;
    end
    task chk(string n, logic [10:0] e, g);
        total_checks++;
        if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
        err_total += (g !== e);
    endtask
    task op(logic [2:0] c, logic [7:0] v, logic [10:0] s = 11'h000);
        @(posedge SYS_CLK) #1;
        {OP_CODE, OP_IMM, OP_ADDR, STACK_TOP, OP_VALID} = {c, v, v, s, 1'b1};
        @(posedge SYS_CLK) #1;
        OP_VALID = 1'b0;
        for (int n = 0; n < 6 && OP_DONE !== 1'b1; n++) @(posedge SYS_CLK) #1;
    endtask
    task t_or;
        mem[8'h3c] = 8'h42;
        op(3'h1, 8'ha5);
        chk("wreg", 8'ha5, WORK_REG);
        chk("nil", 1'b0, NIL_FLAG);
        op(3'h2, 8'h3c);
        chk("mem", 8'ha5 | 8'h42, mem[8'h3c]);
        chk("nil", 1'b0, NIL_FLAG);
    endtask
    task t_exit;
        chk("ien", 1'b0, INT_ENABLE);
        op(3'h3, 8'h00, 11'h123);
        chk("pc", 11'h123, PC_VALUE);
        chk("nil", 1'b0, NIL_FLAG);
        op(3'h4, 8'h00, 11'h456);
        chk("wreg", 8'h00, WORK_REG);
        chk("pc", 11'h456, PC_VALUE);
        chk("nil", 1'b0, NIL_FLAG);
        op(3'h5, 8'h00, 11'h7ff);
        chk("take", 1'b1, IRQ_TAKE);
        chk("ien", 1'b1, INT_ENABLE);
        chk("pc", 11'h7ff, PC_VALUE);
        IRQ_PENDING = 1'b0;
        op(3'h5, 8'h00, 11'h2a5);
        chk("take", 1'b0, IRQ_TAKE);
        chk("pc", 11'h2a5, PC_VALUE);
        @(posedge SYS_CLK) #1;
        chk("pops", 11'h004, 11'(pops));
    endtask
    task t_rot;
        op(3'h1, 8'h00);
        mem[8'h81] = 8'h81;
        op(3'h6, 8'h81);
        chk("mem", 8'h03, mem[8'h81]);
        chk("nil", 1'b1, NIL_FLAG);
        op(3'h7, 8'h81);
        chk("wreg", 8'h06, WORK_REG);
        chk("mem", 8'h03, mem[8'h81]);
        chk("nil", 1'b1, NIL_FLAG);
    endtask
    task finish_test;
        err_total += (cyc >= 3000);
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge SYS_CLK);
        #1 SYS_RST = 1'b0;
        t_or;
        t_exit;
        t_rot;
        finish_test;
    end
endmodule
`default_nettype wire
